/* axs_enable_seq.sv */
// Enable sequencer for the third auxiliary regulator with neighbour enable options
`timescale 1ns/1ns
module axs_enable_seq
   import axs_pkg::*;
#(
   parameter int TICKS = TICK_CYCLES
)(
   input  wire logic        clock,
   input  wire logic        reset,
   input  wire logic        regWrite,
   input  wire logic        regRead,
   input  wire logic [7:0]  regAddr,
   input  wire logic [7:0]  regWdata,
   output logic      [7:0]  regRdata,
   input  wire logic [5:0]  controlInputs,
   input  wire logic        aux2Good,
   input  wire logic        aSwitchGood,
   input  wire logic [5:0]  railGood,
   input  wire logic        sharedRailGood,
   input  wire logic        b1SwitchGood,
   input  wire logic        sleepInput,
   input  wire logic        rail6CoarseStep,
   input  wire logic        b1SwitchLogic,
   input  wire logic        b2SwitchLogic,
   input  wire logic        firstAuxLogic,
   output logic             aux3Enable,
   output logic             b2SwitchEnable,
   output logic             firstAuxEnable,
   output logic             rail6PinVoltReq,
   output logic      [11:0] rail6PinVoltMv
);

   logic [7:0]   maskPrimary_q, maskPrimary_d;
   logic [7:0]   pinSelect_q, pinSelect_d;
   logic [7:0]   edgeDelay_q, edgeDelay_d;
   logic [7:0]   rdata_q, rdata_d;
   logic         b2Enable_q, b2Enable_d;
   logic         firstAux_q, firstAux_d;
   logic         voltReq_q, voltReq_d;
   logic [11:0]  voltMv_q, voltMv_d;
   axs_pin_sel_t pinSel;
   logic         selectedPin;
   logic [7:0]   goodPrimary;
   logic         goodOk;
   logic         enableCond;
   logic         shareOpt;
   logic         swapOpt;

   axs_delay_if dlyBus ();

   // Register file writes and reads
   always_comb
   begin
      maskPrimary_d = maskPrimary_q;
      pinSelect_d   = pinSelect_q;
      edgeDelay_d   = edgeDelay_q;
      rdata_d       = rdata_q;
      if (regWrite)
      begin
         if (regAddr == ADDR_MASK_PRIMARY)
            maskPrimary_d = regWdata;
         if (regAddr == ADDR_PIN_SELECT)
            pinSelect_d = regWdata;
         if (regAddr == ADDR_EDGE_DELAY)
            edgeDelay_d = regWdata;
      end
      if (regRead)
      begin
         if (regAddr == ADDR_MASK_PRIMARY)
            rdata_d = maskPrimary_q;
         else if (regAddr == ADDR_PIN_SELECT)
            rdata_d = pinSelect_q;
         else if (regAddr == ADDR_EDGE_DELAY)
            rdata_d = edgeDelay_q;
         else
            rdata_d = READ_UNMAPPED;
      end
   end

   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         maskPrimary_q <= REG_RESET;
         pinSelect_q   <= REG_RESET;
         edgeDelay_q   <= REG_RESET;
         rdata_q       <= REG_RESET;
      end
      else
      begin
         maskPrimary_q <= maskPrimary_d;
         pinSelect_q   <= pinSelect_d;
         edgeDelay_q   <= edgeDelay_d;
         rdata_q       <= rdata_d;
      end
   end

   assign regRdata = rdata_q;

   // Enable source multiplexer
   assign pinSel = axs_pin_sel_t'(pinSelect_q[SEL_MSB:SEL_LSB]);

   always_comb
   begin
      selectedPin = 1'b0;
      unique case (pinSel)
         SEL_INPUT_ONE:   selectedPin = controlInputs[0];
         SEL_INPUT_TWO:   selectedPin = controlInputs[1];
         SEL_INPUT_FIVE:  selectedPin = controlInputs[4];
         SEL_INPUT_FOUR:  selectedPin = controlInputs[3];
         SEL_INPUT_THREE: selectedPin = controlInputs[2];
         SEL_THREE_FOUR:  selectedPin = controlInputs[2] & controlInputs[3];
         SEL_INPUT_SIX:   selectedPin = controlInputs[5];
         SEL_ALWAYS_ON:   selectedPin = 1'b1;
      endcase
   end

   // Good flags in the bit order of the first mask register
   assign goodPrimary = {aux2Good, aSwitchGood, railGood[5:0]};

   // A set mask bit forces its flag to count as good
   assign goodOk = &(goodPrimary | maskPrimary_q)
                 & (sharedRailGood | pinSelect_q[MASK2_SHARED_BIT])
                 & (b1SwitchGood | pinSelect_q[MASK2_B1_BIT]);

   // Gating before the delay means a lost flag also waits out the turn-off delay
   assign enableCond = selectedPin & goodOk;

   assign dlyBus.level    = enableCond;
   assign dlyBus.riseCode = edgeDelay_q[RISE_MSB:RISE_LSB];
   assign dlyBus.fallCode = edgeDelay_q[FALL_MSB:FALL_LSB];

   axs_edge_delay #(
      .TICKS (TICKS)
   ) edgeDelay (
      .clock (clock),
      .reset (reset),
      .dly   (dlyBus.filter)
   );

   assign aux3Enable = dlyBus.delayed;

   // Neighbour enable routing and rail six pin voltage
   assign shareOpt = edgeDelay_q[SHARE_BIT];
   assign swapOpt  = edgeDelay_q[SWAP_BIT];

   always_comb
   begin
      b2Enable_d = b2SwitchLogic;
      firstAux_d = firstAuxLogic;
      if (swapOpt)
      begin
         b2Enable_d = firstAuxLogic;
         firstAux_d = b2SwitchLogic;
      end
      else if (shareOpt)
         b2Enable_d = b1SwitchLogic;
      voltReq_d = pinSelect_q[VOPT_BIT] & controlInputs[1] & ~sleepInput;
      voltMv_d  = rail6CoarseStep ? RAIL6_PIN_MV_COARSE : RAIL6_PIN_MV_FINE;
   end

   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         b2Enable_q <= 1'b0;
         firstAux_q <= 1'b0;
         voltReq_q  <= 1'b0;
         voltMv_q   <= RAIL6_PIN_MV_FINE;
      end
      else
      begin
         b2Enable_q <= b2Enable_d;
         firstAux_q <= firstAux_d;
         voltReq_q  <= voltReq_d;
         voltMv_q   <= voltMv_d;
      end
   end

   assign b2SwitchEnable  = b2Enable_q;
   assign firstAuxEnable  = firstAux_q;
   assign rail6PinVoltReq = voltReq_q;
   assign rail6PinVoltMv  = voltMv_q;

   chk_mask_include: assert property (@(posedge clock) disable iff (reset)
      (!maskPrimary_q[5] && !railGood[5]) |-> !enableCond)
      else $error("Unmasked bad rail six flag did not block enabling");

   chk_mask_map: assert property (@(posedge clock) disable iff (reset)
      (selectedPin && !aux2Good && !maskPrimary_q[7]) |-> !enableCond)
      else $error("Aux2 good flag not mapped to mask bit 7");

   chk_mask_second: assert property (@(posedge clock) disable iff (reset)
      (!pinSelect_q[1] && !sharedRailGood) || (!pinSelect_q[0] && !b1SwitchGood) |-> !enableCond)
      else $error("Second mask register flag not applied");

   chk_pin_pair: assert property (@(posedge clock) disable iff (reset)
      (pinSel == SEL_THREE_FOUR) |-> (selectedPin == (controlInputs[2] && controlInputs[3])))
      else $error("Combined input three and four selection wrong");

   chk_const_one: assert property (@(posedge clock) disable iff (reset)
      (pinSel == SEL_ALWAYS_ON && maskPrimary_q == 8'hff && pinSelect_q[1:0] == 2'h3
       && edgeDelay_q[2:0] == 3'h0) |=> aux3Enable)
      else $error("Always-on select with all masks did not enable");

   chk_rise_zero: assert property (@(posedge clock) disable iff (reset)
      ($rose(enableCond) && edgeDelay_q[2:0] == 3'h0 && !aux3Enable) |=> aux3Enable)
      else $error("Rising edge with no delay not passed in one cycle");

   chk_rise_held: assert property (@(posedge clock) disable iff (reset)
      ($rose(enableCond) && edgeDelay_q[2:0] != 3'h0 && !aux3Enable) |=> !aux3Enable [*8])
      else $error("Rising edge passed before its delay");

   chk_fall_zero: assert property (@(posedge clock) disable iff (reset)
      ($fell(enableCond) && edgeDelay_q[5:3] == 3'h0 && aux3Enable) |=> !aux3Enable)
      else $error("Falling edge with no delay not passed in one cycle");

   chk_enable_cause: assert property (@(posedge clock) disable iff (reset)
      $rose(aux3Enable) |-> $past(enableCond))
      else $error("Enable rose without its condition");

   chk_b_shared: assert property (@(posedge clock) disable iff (reset)
      (shareOpt && !swapOpt) |=> (b2SwitchEnable == $past(b1SwitchLogic)))
      else $error("Second b switch not following first");

   chk_swap_route: assert property (@(posedge clock) disable iff (reset)
      swapOpt |=> (firstAuxEnable == $past(b2SwitchLogic) && b2SwitchEnable == $past(firstAuxLogic)))
      else $error("Regulator and switch enables not swapped");

   chk_rail6_volt: assert property (@(posedge clock) disable iff (reset)
      (pinSelect_q[7] && controlInputs[1] && !sleepInput) |=> rail6PinVoltReq)
      else $error("Rail six pin voltage request missing");

   chk_rail6_coarse: assert property (@(posedge clock) disable iff (reset)
      rail6CoarseStep |=> (rail6PinVoltMv == RAIL6_PIN_MV_COARSE))
      else $error("Coarse step pin voltage not 2.4 V");

   chk_sleep_wins: assert property (@(posedge clock) disable iff (reset)
      sleepInput |=> !rail6PinVoltReq)
      else $error("Sleep did not override pin voltage");

   cov_enable_on: cover property (@(posedge clock) disable iff (reset) $rose(aux3Enable));
   cov_enable_off: cover property (@(posedge clock) disable iff (reset) $fell(aux3Enable));
   cov_swap: cover property (@(posedge clock) disable iff (reset) swapOpt && b2SwitchEnable);
   cov_volt: cover property (@(posedge clock) disable iff (reset) rail6PinVoltReq);

endmodule : axs_enable_seq

/* axs_pkg.sv */
// Constants and types shared by the third auxiliary regulator enable sequencer
package axs_pkg;

   localparam logic [7:0] ADDR_MASK_PRIMARY = 8'h1f;
   localparam logic [7:0] ADDR_PIN_SELECT   = 8'h20;
   localparam logic [7:0] ADDR_EDGE_DELAY   = 8'h21;
   localparam logic [7:0] REG_RESET         = 8'h00;
   localparam logic [7:0] READ_UNMAPPED     = 8'h00;

   localparam int MASK2_SHARED_BIT = 1;
   localparam int MASK2_B1_BIT     = 0;
   localparam int SEL_LSB          = 2;
   localparam int SEL_MSB          = 4;
   localparam int VOPT_BIT         = 7;
   localparam int RISE_LSB         = 0;
   localparam int RISE_MSB         = 2;
   localparam int FALL_LSB         = 3;
   localparam int FALL_MSB         = 5;
   localparam int SWAP_BIT         = 6;
   localparam int SHARE_BIT        = 7;

   localparam int CLOCK_PERIOD_NS = 10;
   localparam int TICK_PERIOD_MS  = 1;
   localparam int TICK_CYCLES     = TICK_PERIOD_MS * 1000000 / CLOCK_PERIOD_NS;

   localparam int MS_WIDTH = 7;
   localparam logic [MS_WIDTH-1:0] DELAY_MS [8] = '{7'h00, 7'h02, 7'h04, 7'h08, 7'h10, 7'h18, 7'h20, 7'h40};

   localparam logic [11:0] RAIL6_PIN_MV_FINE   = 12'h4b0;
   localparam logic [11:0] RAIL6_PIN_MV_COARSE = 12'h960;

   typedef enum logic [2:0] {
      SEL_INPUT_ONE   = 3'h0,
      SEL_INPUT_TWO   = 3'h1,
      SEL_INPUT_FIVE  = 3'h2,
      SEL_INPUT_FOUR  = 3'h3,
      SEL_INPUT_THREE = 3'h4,
      SEL_THREE_FOUR  = 3'h5,
      SEL_INPUT_SIX   = 3'h6,
      SEL_ALWAYS_ON   = 3'h7
   } axs_pin_sel_t;

   typedef enum logic [0:0] {
      DLY_IDLE = 1'h0,
      DLY_RUN  = 1'h1
   } axs_dly_state_t;

endpackage : axs_pkg

/* axs_delay_if.sv */
// Carrier between the sequencer and its edge delay filter
`timescale 1ns/1ns
interface axs_delay_if;
   logic       level;
   logic [2:0] riseCode;
   logic [2:0] fallCode;
   logic       delayed;

   modport owner  (output level, output riseCode, output fallCode, input delayed);
   modport filter (input level, input riseCode, input fallCode, output delayed);
endinterface : axs_delay_if

/* axs_edge_delay.sv */
// Edge delay filter: rising and falling edges of a level are held off by coded millisecond delays
`timescale 1ns/1ns
module axs_edge_delay
   import axs_pkg::*;
#(
   parameter int TICKS = TICK_CYCLES
)(
   input  wire logic   clock,
   input  wire logic   reset,
   axs_delay_if.filter dly
);
   localparam int PW = $clog2(TICKS);

   axs_dly_state_t        state_q, state_d;
   logic                  out_q, out_d;
   logic [PW-1:0]         prescale_q, prescale_d;
   logic [MS_WIDTH-1:0]   msCount_q, msCount_d;
   logic [MS_WIDTH-1:0]   target;

   always_comb
   begin
      state_d    = state_q;
      out_d      = out_q;
      prescale_d = prescale_q;
      msCount_d  = msCount_q;
      target     = dly.level ? DELAY_MS[dly.riseCode] : DELAY_MS[dly.fallCode];
      unique case (state_q)
         DLY_IDLE:
         begin
            if (dly.level != out_q)
            begin
               if (target == '0)
                  out_d = dly.level;
               else
               begin
                  // Prescaler restarts on each edge so the delay is exact to a cycle
                  state_d    = DLY_RUN;
                  prescale_d = '0;
                  msCount_d  = '0;
               end
            end
         end
         DLY_RUN:
         begin
            if (dly.level == out_q)
               state_d = DLY_IDLE;
            else if (target == '0)
            begin
               // A code rewritten to no delay mid-count takes effect at once
               out_d   = dly.level;
               state_d = DLY_IDLE;
            end
            else if (prescale_q == PW'(TICKS - 1))
            begin
               prescale_d = '0;
               // Greater-or-equal ends the wait if the code is shortened mid-count
               if (msCount_q + 7'h01 >= target)
               begin
                  out_d   = dly.level;
                  state_d = DLY_IDLE;
               end
               else
                  msCount_d = msCount_q + 7'h01;
            end
            else
               prescale_d = prescale_q + PW'(1);
         end
      endcase
   end

   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         state_q    <= DLY_IDLE;
         out_q      <= 1'b0;
         prescale_q <= '0;
         msCount_q  <= '0;
      end
      else
      begin
         state_q    <= state_d;
         out_q      <= out_d;
         prescale_q <= prescale_d;
         msCount_q  <= msCount_d;
      end
   end

   assign dly.delayed = out_q;

   chk_ms_bound: assert property (@(posedge clock) disable iff (reset)
      msCount_q < 7'h40)
      else $error("Millisecond count ran past the longest delay");

endmodule : axs_edge_delay

/* axs_far_side.sv */
// Far-side model: good flags of the other rails and their own enable results
`timescale 1ns/1ns
module axs_far_side (
   input  wire logic       dropOn,
   input  wire logic [3:0] dropSel,
   input  wire logic [2:0] nbrCmd,
   output logic      [9:0] goodVec,
   output logic      [2:0] nbrLogic
);
   // One rail at a time reads bad, so each mask bit is seen on its own
   assign goodVec  = dropOn ? ~(10'h001 << dropSel) : 10'h3ff;
   assign nbrLogic = nbrCmd;
endmodule : axs_far_side

/* tb_top.sv */
// Self-checking bench for the third auxiliary regulator enable sequencer
`timescale 1ns/1ns
module tb_top
   import axs_pkg::*;
;
   localparam int TK = 10;
   logic        clock    = 1'b0;
   logic        reset    = 1'b1;
   logic        regWrite = 1'b0;
   logic        regRead  = 1'b0;
   logic [7:0]  regAddr  = 8'h00;
   logic [7:0]  regWdata = 8'h00;
   logic [5:0]  controlInputs   = 6'h00;
   logic        sleepInput      = 1'b0;
   logic        rail6CoarseStep = 1'b0;
   logic        dropOn   = 1'b0;
   logic [3:0]  dropSel  = 4'h0;
   logic [2:0]  nbrCmd   = 3'h0;
   logic [2:0]  nbrLogic;
   logic [9:0]  goodVec;
   logic [7:0]  regRdata;
   logic        aux3Enable, b2SwitchEnable, firstAuxEnable, rail6PinVoltReq;
   logic [11:0] rail6PinVoltMv;
   logic [7:0]  expQ[$];
   logic [31:0] lfsr = 32'h34f2;
   logic [7:0]  ra[3] = '{ADDR_MASK_PRIMARY, ADDR_PIN_SELECT, ADDR_EDGE_DELAY};
   int          ms[8] = '{0, 2, 4, 8, 16, 24, 32, 64};
   int          fail_count = 0;
   int          n_compared = 0;

   axs_enable_seq #(.TICKS(TK)) u_dut (
      .clock, .reset, .regWrite, .regRead, .regAddr, .regWdata, .regRdata, .controlInputs,
      .aux2Good(goodVec[9]), .aSwitchGood(goodVec[8]), .railGood(goodVec[7:2]),
      .sharedRailGood(goodVec[1]), .b1SwitchGood(goodVec[0]), .sleepInput, .rail6CoarseStep,
      .b1SwitchLogic(nbrLogic[0]), .b2SwitchLogic(nbrLogic[1]), .firstAuxLogic(nbrLogic[2]),
      .aux3Enable, .b2SwitchEnable, .firstAuxEnable, .rail6PinVoltReq, .rail6PinVoltMv
   );
   axs_far_side u_far (.dropOn, .dropSel, .nbrCmd, .goodVec, .nbrLogic);

   initial
   begin
      forever #5 clock = ~clock;
   end

   task automatic report_and_stop;
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : report_and_stop

   task automatic check(input string what, input logic [11:0] exp, input logic [11:0] seen);
      n_compared++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : nxt

   function automatic logic pin_exp(input logic [2:0] s, input logic [5:0] c);
      case (s)
         3'h0: return c[0];
         3'h1: return c[1];
         3'h2: return c[4];
         3'h3: return c[3];
         3'h4: return c[2];
         3'h5: return c[2] & c[3];
         3'h6: return c[5];
         default: return 1'b1;
      endcase
   endfunction : pin_exp

   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : cyc

   // A spare cycle after each access keeps the strobe from being set twice in one step
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      regAddr = a;
      regWdata = d;
      regWrite = 1'b1;
      cyc(1);
      regWrite = 1'b0;
      cyc(1);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      expQ.push_back(e);
      regAddr = a;
      regRead = 1'b1;
      cyc(1);
      regRead = 1'b0;
      cyc(1);
   endtask : rd

   task automatic meas(input logic lvl, input int exp);
      int n;
      n = 0;
      do
      begin
         cyc(1);
         n++;
      end
      while (aux3Enable !== lvl && n < 1000);
      check("delay cycles", 12'(exp), 12'(n));
      if (n >= 1000)
         report_and_stop();
   endtask : meas

   always @(posedge clock)
   begin
      if (regRead === 1'b1)
      begin
         #2;
         check("read data", expQ.pop_front(), regRdata);
      end
   end

   initial
   begin
      repeat (20) @(posedge clock);
      #1;
      reset = 1'b0;
      foreach (ra[i]) rd(ra[i], 8'h00);
      foreach (ra[i])
      begin
         lfsr = nxt(lfsr);
         wr(ra[i], lfsr[7:0]);
         rd(ra[i], lfsr[7:0]);
      end
      wr(8'h22, 8'h5a);
      rd(8'h22, 8'h00);
      // Neighbour and step inputs held active so the reset values are really tested
      nbrCmd = 3'h7;
      rail6CoarseStep = 1'b1;
      reset = 1'b1;
      cyc(2);
      check("reset enable", 1'b0, aux3Enable);
      check("reset b2 switch", 1'b0, b2SwitchEnable);
      check("reset first aux", 1'b0, firstAuxEnable);
      check("reset rail6 req", 1'b0, rail6PinVoltReq);
      check("reset rail6 mv", RAIL6_PIN_MV_FINE, rail6PinVoltMv);
      nbrCmd = 3'h0;
      rail6CoarseStep = 1'b0;
      reset = 1'b0;
      foreach (ra[i]) rd(ra[i], 8'h00);
      $display("test registers done");
      for (int s = 0; s < 8; s++)
      begin
         wr(ADDR_PIN_SELECT, 8'(s << 2));
         repeat (4)
         begin
            lfsr = nxt(lfsr);
            controlInputs = lfsr[5:0];
            cyc(2);
            check("pin select", pin_exp(3'(s), lfsr[5:0]), aux3Enable);
         end
      end
      $display("test pin select done");
      wr(ADDR_PIN_SELECT, 8'h1c);
      for (int i = 0; i < 10; i++)
      begin
         dropOn = 1'b1;
         dropSel = 4'(i);
         cyc(2);
         check("unmasked flag", 1'b0, aux3Enable);
         if (i < 2)
            wr(ADDR_PIN_SELECT, 8'h1c | 8'(1 << i));
         else
            wr(ADDR_MASK_PRIMARY, 8'(1 << (i - 2)));
         cyc(1);
         check("masked flag", 1'b1, aux3Enable);
         wr(ADDR_MASK_PRIMARY, 8'h00);
         wr(ADDR_PIN_SELECT, 8'h1c);
      end
      dropSel = 4'h0;
      wr(ADDR_MASK_PRIMARY, 8'hff);
      check("b1 flag unmasked", 1'b0, aux3Enable);
      wr(ADDR_PIN_SELECT, 8'h1f);
      check("all masked", 1'b1, aux3Enable);
      wr(ADDR_MASK_PRIMARY, 8'h00);
      $display("test masks done");
      wr(ADDR_PIN_SELECT, 8'h00);
      controlInputs = 6'h00;
      dropOn = 1'b0;
      cyc(2);
      for (int c = 0; c < 8; c++)
      begin
         wr(ADDR_EDGE_DELAY, 8'(((7 - c) << 3) | c));
         controlInputs = 6'h01;
         meas(1'b1, ms[c] * TK + 1);
         controlInputs = 6'h00;
         meas(1'b0, ms[7 - c] * TK + 1);
      end
      wr(ADDR_EDGE_DELAY, 8'h01);
      controlInputs = 6'h01;
      cyc(TK);
      controlInputs = 6'h00;
      cyc(3 * TK);
      check("short pulse", 1'b0, aux3Enable);
      $display("test delays done");
      for (int j = 0; j < 32; j++)
      begin
         wr(ADDR_EDGE_DELAY, 8'((j >> 3) << 6));
         nbrCmd = 3'(j);
         cyc(1);
         check("b2 switch", j[3] ? j[2] : (j[4] ? j[0] : j[1]), b2SwitchEnable);
         check("first aux", j[3] ? j[1] : j[2], firstAuxEnable);
      end
      $display("test neighbours done");
      for (int j = 0; j < 16; j++)
      begin
         wr(ADDR_PIN_SELECT, {j[3], 7'h00});
         controlInputs = {4'h0, j[0], 1'b0};
         sleepInput = j[1];
         rail6CoarseStep = j[2];
         cyc(1);
         check("rail6 request", j[3] & j[0] & ~j[1], rail6PinVoltReq);
         if (j[3] & j[0] & ~j[1])
            check("rail6 mv", j[2] ? 12'h960 : 12'h4b0, rail6PinVoltMv);
      end
      $display("test rail six done");
      report_and_stop();
   end
endmodule : tb_top
